// file: fac_fault_address_regs.sv
// Purpose: Fault address capture registers and their control block decode.
// Assumes: Requests come from the core load/store port, answered one cycle later.
// Notes:   Only the valid and cause flags of the fault status word are kept here.
`timescale 1ns/1ps
module fac_fault_address_regs
  import fac_pkg::*;
#(
  parameter bit HAS_AUX = 1'b1
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Core register port
  input  wire fac_req_t   req,
  output fac_rsp_t        rsp,
  // Fault events from the core
  input  wire fac_fault_t fault,
  // Status view
  output logic            protValid,
  output logic            busValid
);

  typedef struct packed {
    fac_rsp_t         rsp;
    logic [3:0]       flags;
    logic [2:0][31:0] pri;
    logic [31:0]      vector_table_offset;
    logic [31:0]      system_sleep_control;
    logic [31:0]      aux;
  } fac_state_t;

  fac_state_t  st_r;
  fac_state_t  st_nxt;

  logic [31:0] protAddr;
  logic [31:0] busAddr;
  logic        hitScb;
  logic        hitAux;
  logic [7:0]  off;
  logic        subWordOk;
  logic        aligned;
  logic        mapped;
  logic        accOk;
  logic [3:0]  be;
  logic [31:0] bmask;
  logic        swProt;
  logic        swBus;
  logic [31:0] rdVal;
  logic        setProt;
  logic        setBus;

  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] r;
    r = 4'h0;
    case (sz)
      FAC_SZ_BYTE: r = 4'h1 << a;
      FAC_SZ_HALF: r = a[1] ? 4'hC : 4'h3;
      default:     r = 4'hF;
    endcase
    return r;
  endfunction : lanes

  assign setProt = fault.dataViol;
  assign setBus  = fault.preciseBusErr;

  always_comb begin
    hitScb    = (req.addr[31:8] == FAC_SCB_BASE[31:8]);
    hitAux    = HAS_AUX && (req.addr == FAC_AUX_ADDR);
    off       = req.addr[7:0];
    subWordOk = hitScb && (off[7:2] == FAC_OFF_PRI1[7:2] || off[7:2] == FAC_OFF_PRI2[7:2] ||
                off[7:2] == FAC_OFF_PRI3[7:2] || off[7:2] == FAC_OFF_CONFIGURABLE_FAULT_STATUS[7:2]);
    case (req.size)
      FAC_SZ_BYTE: aligned = 1'b1;
      FAC_SZ_HALF: aligned = ~req.addr[0];
      FAC_SZ_WORD: aligned = (req.addr[1:0] == 2'h0);
      default:     aligned = 1'b0;
    endcase
    mapped = hitAux;
    if (hitScb) begin
      case ({off[7:2], 2'h0})
        FAC_OFF_ID, FAC_OFF_INTERRUPT_CONTROL_STATE, FAC_OFF_VECTOR_TABLE_OFFSET, FAC_OFF_APP_INTERRUPT_RESET_CONTROL, FAC_OFF_SCR,
        FAC_OFF_PRI1, FAC_OFF_PRI2, FAC_OFF_PRI3, FAC_OFF_CONFIGURABLE_FAULT_STATUS,
        FAC_OFF_PFAR, FAC_OFF_BUS_FAULT_ADDRESS: mapped = 1'b1;
        default:                    mapped = 1'b0;
      endcase
    end
    // Sub-word access elsewhere is refused rather than merged, which keeps decode simple.
    accOk = req.priv && aligned && mapped &&
            (req.size == FAC_SZ_WORD || subWordOk);
    be    = lanes(req.size, req.addr[1:0]);
    bmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    swProt = req.valid && req.write && accOk && hitScb && ({off[7:2], 2'h0} == FAC_OFF_PFAR);
    swBus  = req.valid && req.write && accOk && hitScb && ({off[7:2], 2'h0} == FAC_OFF_BUS_FAULT_ADDRESS);
  end

  always_comb begin
    rdVal = FAC_RST_WORD;
    if (hitAux) begin
      rdVal = st_r.aux;
    end else begin
      case ({off[7:2], 2'h0})
        FAC_OFF_ID:   rdVal = FAC_ID_VALUE;
        FAC_OFF_VECTOR_TABLE_OFFSET: rdVal = st_r.vector_table_offset;
        FAC_OFF_SCR:  rdVal = st_r.system_sleep_control;
        FAC_OFF_PRI1: rdVal = st_r.pri[0];
        FAC_OFF_PRI2: rdVal = st_r.pri[1];
        FAC_OFF_PRI3: rdVal = st_r.pri[2];
        FAC_OFF_CONFIGURABLE_FAULT_STATUS: begin
          rdVal[FAC_BIT_DACC]    = st_r.flags[0];
          rdVal[FAC_BIT_PVALID]  = st_r.flags[1];
          rdVal[FAC_BIT_PRECISE] = st_r.flags[2];
          rdVal[FAC_BIT_BVALID]  = st_r.flags[3];
        end
        FAC_OFF_PFAR: rdVal = protAddr;
        FAC_OFF_BUS_FAULT_ADDRESS: rdVal = busAddr;
        default:      rdVal = FAC_RST_WORD;
      endcase
    end
  end

  always_comb begin
    logic [31:0] clr;
    clr = FAC_RST_WORD;
    st_nxt           = st_r;
    st_nxt.rsp.valid = req.valid;
    st_nxt.rsp.err   = req.valid && !accOk;
    if (req.valid && accOk && !req.write) begin
      st_nxt.rsp.rdata = rdVal;
    end
    if (req.valid && accOk && req.write) begin
      if (hitAux) begin
        st_nxt.aux = req.wdata;
      end else begin
        case ({off[7:2], 2'h0})
          FAC_OFF_VECTOR_TABLE_OFFSET: st_nxt.vector_table_offset   = req.wdata;
          FAC_OFF_SCR:  st_nxt.system_sleep_control    = req.wdata;
          FAC_OFF_PRI1: st_nxt.pri[0] = (st_r.pri[0] & ~bmask) | (req.wdata & bmask);
          FAC_OFF_PRI2: st_nxt.pri[1] = (st_r.pri[1] & ~bmask) | (req.wdata & bmask);
          FAC_OFF_PRI3: st_nxt.pri[2] = (st_r.pri[2] & ~bmask) | (req.wdata & bmask);
          FAC_OFF_CONFIGURABLE_FAULT_STATUS: clr = req.wdata & bmask;
          default:      clr = FAC_RST_WORD;
        endcase
      end
    end
    // Flags clear by writing one; a same-cycle hardware set still wins.
    if (clr[FAC_BIT_DACC])    st_nxt.flags[0] = 1'b0;
    if (clr[FAC_BIT_PVALID])  st_nxt.flags[1] = 1'b0;
    if (clr[FAC_BIT_PRECISE]) st_nxt.flags[2] = 1'b0;
    if (clr[FAC_BIT_BVALID])  st_nxt.flags[3] = 1'b0;
    if (fault.dataViol && !setBus) begin
      st_nxt.flags[3] = 1'b0;
    end
    if (setProt) begin
      st_nxt.flags[0] = 1'b1;
      st_nxt.flags[1] = 1'b1;
    end
    if (setBus) begin
      st_nxt.flags[2] = 1'b1;
      st_nxt.flags[3] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r.rsp   <= '0;
      st_r.flags <= FAC_RST_FLAGS;
      st_r.pri   <= '0;
      st_r.vector_table_offset  <= FAC_RST_WORD;
      st_r.system_sleep_control   <= FAC_RST_WORD;
      st_r.aux   <= FAC_RST_WORD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The sub-access address comes straight from the core, so any split piece can be captured.
  fac_capture_reg #(.WIDTH(32)) u_protAddr (
    .clk_sys (clk_sys),
    .capEn   (setProt),
    .capAddr (fault.dataViolAddr),
    .swEn    (swProt),
    .swData  (req.wdata),
    .value   (protAddr)
  );

  fac_capture_reg #(.WIDTH(32)) u_busAddr (
    .clk_sys (clk_sys),
    .capEn   (setBus),
    .capAddr (fault.busReqAddr),
    .swEn    (swBus),
    .swData  (req.wdata),
    .value   (busAddr)
  );

  assign rsp       = st_r.rsp;
  assign protValid = st_r.flags[1];
  assign busValid  = st_r.flags[3];

  property p_protCapture;
    @(posedge clk_sys) disable iff (rst)
    fault.dataViol |=> (protAddr == $past(fault.dataViolAddr)) && protValid;
  endproperty
  a_protCapture: assert property (p_protCapture) else $error("Protection address not captured.");

  property p_busCapture;
    @(posedge clk_sys) disable iff (rst)
    fault.preciseBusErr |=> (busAddr == $past(fault.busReqAddr)) && busValid;
  endproperty
  a_busCapture: assert property (p_busCapture) else $error("Bus fault address not captured.");

  property p_busClearedByMem;
    @(posedge clk_sys) disable iff (rst)
    fault.dataViol && !fault.preciseBusErr |=> !busValid;
  endproperty
  a_busClearedByMem: assert property (p_busClearedByMem) else $error("Bus flag not cleared.");

  property p_busNoWrite;
    @(posedge clk_sys) disable iff (rst)
    !fault.preciseBusErr && !swBus |=> $stable(busAddr);
  endproperty
  a_busNoWrite: assert property (p_busNoWrite) else $error("Bus fault address changed unexpectedly.");

  property p_protNoWrite;
    @(posedge clk_sys) disable iff (rst)
    !fault.dataViol && !swProt |=> $stable(protAddr);
  endproperty
  a_protNoWrite: assert property (p_protNoWrite) else $error("Protection address changed unexpectedly.");

  property p_unalignedErr;
    @(posedge clk_sys) disable iff (rst)
    req.valid && req.size == FAC_SZ_WORD && req.addr[1:0] != 2'h0 |=> rsp.valid && rsp.err;
  endproperty
  a_unalignedErr: assert property (p_unalignedErr) else $error("Unaligned access accepted.");

  property p_byteStatusOk;
    @(posedge clk_sys) disable iff (rst)
    req.valid && req.priv && req.size == FAC_SZ_BYTE && req.addr[31:2] == {FAC_SCB_BASE[31:8], FAC_OFF_CONFIGURABLE_FAULT_STATUS[7:2]}
      |=> rsp.valid && !rsp.err;
  endproperty
  a_byteStatusOk: assert property (p_byteStatusOk) else $error("Byte access to status refused.");

  property p_userRefused;
    @(posedge clk_sys) disable iff (rst)
    req.valid && !req.priv |=> rsp.err;
  endproperty
  a_userRefused: assert property (p_userRefused) else $error("Unprivileged access accepted.");

  property p_idRead;
    @(posedge clk_sys) disable iff (rst)
    req.valid && req.priv && !req.write && req.size == FAC_SZ_WORD && req.addr == FAC_SCB_BASE
      |=> rsp.rdata == FAC_ID_VALUE && !rsp.err;
  endproperty
  a_idRead: assert property (p_idRead) else $error("Identity word wrong.");

  property p_validWithFlagSet;
    @(posedge clk_sys) disable iff (rst)
    !protValid ##1 protValid |-> $past(fault.dataViol);
  endproperty
  a_validWithFlagSet: assert property (p_validWithFlagSet) else $error("Flag set without fault.");

  property p_unmappedErr;
    @(posedge clk_sys) disable iff (rst)
    req.valid && !mapped |=> rsp.valid && rsp.err;
  endproperty
  a_unmappedErr: assert property (p_unmappedErr) else $error("Unmapped access accepted.");

  property p_oddHalfErr;
    @(posedge clk_sys) disable iff (rst)
    req.valid && req.size == FAC_SZ_HALF && req.addr[0] |=> rsp.valid && rsp.err;
  endproperty
  a_oddHalfErr: assert property (p_oddHalfErr) else $error("Odd halfword access accepted.");

  property p_wordOnlyElsewhere;
    @(posedge clk_sys) disable iff (rst)
    req.valid && hitScb && !subWordOk && req.size != FAC_SZ_WORD |=> rsp.err;
  endproperty
  a_wordOnlyElsewhere: assert property (p_wordOnlyElsewhere) else $error("Sub-word access accepted.");

  property p_refusedWriteKeeps;
    @(posedge clk_sys) disable iff (rst)
    req.valid && req.write && !accOk |=> $stable(st_r.vector_table_offset) && $stable(st_r.pri);
  endproperty
  a_refusedWriteKeeps: assert property (p_refusedWriteKeeps) else $error("Refused write changed state.");

endmodule : fac_fault_address_regs

// file: fac_pkg.sv
// Purpose: Shared constants and carrier types for the fault address capture block.
// Assumes: One processor clock, registers reached by the core's privileged load/store port.
// Notes:   Offsets are byte offsets from the control block base.
package fac_pkg;

  localparam logic [31:0] FAC_SCB_BASE      = 32'hE000_ED00;
  localparam logic [31:0] FAC_AUX_ADDR      = 32'hE000_E008;
  // Identification value is arbitrary, not taken from any real part.
  localparam logic [31:0] FAC_ID_VALUE      = 32'h1234_5678;

  localparam logic [7:0]  FAC_OFF_ID        = 8'h00;
  localparam logic [7:0]  FAC_OFF_INTERRUPT_CONTROL_STATE      = 8'h04;
  localparam logic [7:0]  FAC_OFF_VECTOR_TABLE_OFFSET      = 8'h08;
  localparam logic [7:0]  FAC_OFF_APP_INTERRUPT_RESET_CONTROL     = 8'h0C;
  localparam logic [7:0]  FAC_OFF_SCR       = 8'h10;
  localparam logic [7:0]  FAC_OFF_PRI1      = 8'h18;
  localparam logic [7:0]  FAC_OFF_PRI2      = 8'h1C;
  localparam logic [7:0]  FAC_OFF_PRI3      = 8'h20;
  localparam logic [7:0]  FAC_OFF_CONFIGURABLE_FAULT_STATUS      = 8'h28;
  localparam logic [7:0]  FAC_OFF_PFAR      = 8'h34;
  localparam logic [7:0]  FAC_OFF_BUS_FAULT_ADDRESS      = 8'h38;

  localparam int          FAC_BIT_DACC      = 1;
  localparam int          FAC_BIT_PVALID    = 7;
  localparam int          FAC_BIT_PRECISE   = 9;
  localparam int          FAC_BIT_BVALID    = 15;

  localparam logic [1:0]  FAC_SZ_BYTE       = 2'h0;
  localparam logic [1:0]  FAC_SZ_HALF       = 2'h1;
  localparam logic [1:0]  FAC_SZ_WORD       = 2'h2;

  localparam logic [31:0] FAC_RST_WORD      = 32'h0000_0000;
  localparam logic [3:0]  FAC_RST_FLAGS     = 4'h0;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fac_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } fac_rsp_t;

  typedef struct packed {
    logic        dataViol;
    logic [31:0] dataViolAddr;
    logic        preciseBusErr;
    logic [31:0] busReqAddr;
    logic        otherMemFault;
    logic        otherBusFault;
  } fac_fault_t;

endpackage : fac_pkg

// file: fac_capture_reg.sv
// Purpose: One 32-bit fault address register, loaded by hardware capture or software write.
// Assumes: Capture and write arrive as one-cycle strobes on clk_sys.
// Notes:   Contents are undefined after reset, so the register has no reset.
`timescale 1ns/1ps
module fac_capture_reg
  import fac_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Clock
  input  wire logic             clk_sys,
  // Hardware capture
  input  wire logic             capEn,
  input  wire logic [WIDTH-1:0] capAddr,
  // Software write
  input  wire logic             swEn,
  input  wire logic [WIDTH-1:0] swData,
  // Stored value
  output logic      [WIDTH-1:0] value
);

  typedef struct packed {
    logic [WIDTH-1:0] addr;
  } fac_cap_state_t;

  fac_cap_state_t st_r;
  fac_cap_state_t st_nxt;

  // A capture beats a same-cycle software write so that a fault is never lost.
  always_comb begin
    st_nxt = st_r;
    if (capEn) begin
      st_nxt.addr = capAddr;
    end else if (swEn) begin
      st_nxt.addr = swData;
    end
  end

  always_ff @(posedge clk_sys) begin
    st_r <= st_nxt;
  end

  assign value = st_r.addr;

endmodule : fac_capture_reg

// file: fac_core_model.sv
// Purpose: Core-side model that drives the register port and the fault events.
// Assumes: Every input of the block changes at the falling edge of clk_sys.
// Notes:   Released address and data lines take the inverse of their last value, so stale data cannot pass.
`timescale 1ns/1ps
module fac_core_model
  import fac_pkg::*;
(
  // Clock
  input  wire logic     clk_sys,
  // Register port
  output fac_req_t      req,
  input  wire fac_rsp_t rsp,
  // Fault events
  output fac_fault_t    fault
);
  initial begin
    req   = '0;
    fault = '0;
  end

  // Software keeps to aligned accesses of legal size, except where refusal is the point.
  task automatic access(input logic wr, input logic pv, input logic [1:0] sz, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(negedge clk_sys);
    req = '{valid: 1'b1, write: wr, priv: pv, size: sz, addr: a, wdata: wd};
    @(negedge clk_sys);
    req.valid = 1'b0;
    req.wdata = ~wd;
    req.addr  = ~a;
    while (rsp.valid !== 1'b1 && n < 3) begin
      @(negedge clk_sys);
      n++;
    end
    rd = rsp.rdata;
    er = (rsp.valid === 1'b1) ? rsp.err : 1'bx;
  endtask : access

  task automatic raise(input fac_fault_t f);
    @(negedge clk_sys);
    fault = f;
    @(negedge clk_sys);
    fault              = '0;
    fault.dataViolAddr = ~f.dataViolAddr;
    fault.busReqAddr   = ~f.busReqAddr;
  endtask : raise
endmodule : fac_core_model

// file: tb.sv
// Purpose: Self-checking bench for the fault address capture registers.
// Assumes: Register answers arrive within four cycles of the request.
// Notes:   Expected values come from the register map and fault rules only.
`timescale 1ns/1ps
module tb;
  import fac_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  fac_req_t    req;
  fac_rsp_t    rsp;
  fac_fault_t  fault;
  fac_fault_t  f;
  logic        protValid;
  logic        busValid;
  logic [31:0] rdat;
  int          errCount    = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  logic [7:0]  offs [2]    = '{FAC_OFF_PFAR, FAC_OFF_BUS_FAULT_ADDRESS};
  logic [1:0]  tSz [8]     = '{FAC_SZ_BYTE, FAC_SZ_HALF, FAC_SZ_HALF, FAC_SZ_HALF,
                               FAC_SZ_WORD, 2'h3, FAC_SZ_HALF, FAC_SZ_BYTE};
  logic [7:0]  tOff [8]    = '{8'h19, 8'h2A, 8'h22, 8'h1D, 8'h1A, 8'h18, 8'h08, 8'h00};
  logic        tErr [8]    = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  always #5 clk_sys = ~clk_sys;

  fac_core_model i_core (.clk_sys(clk_sys), .req(req), .rsp(rsp), .fault(fault));

  fac_fault_address_regs #(.HAS_AUX(1'b1)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp), .fault(fault),
    .protValid(protValid), .busValid(busValid)
  );

  function automatic logic [31:0] sa(input logic [7:0] o);
    return FAC_SCB_BASE + {24'h0, o};
  endfunction : sa

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic pv, input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] wd, input logic eErr);
    logic e;
    i_core.access(wr, pv, sz, a, wd, rdat, e);
    chk({31'h0, e}, {31'h0, eErr});
  endtask : bus

  // The address is saved before its flag is looked at, as a handler must.
  task automatic handler(input logic [7:0] off, input logic [31:0] a, input logic [31:0] m);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(off), '0, 1'b0);
    chk(rdat, a);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(FAC_OFF_CONFIGURABLE_FAULT_STATUS), '0, 1'b0);
    chk(rdat & m, m);
  endtask : handler

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errCount++;
      $display("FAIL at %0t: run did not finish in time", $time);
      complete_run();
    end
  end

  initial begin
    f = '0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    chk({30'h0, protValid, busValid}, 32'h0);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(FAC_OFF_ID), '0, 1'b0);
    chk(rdat, FAC_ID_VALUE);
    bus(1'b0, 1'b1, FAC_SZ_WORD, FAC_AUX_ADDR, '0, 1'b0);
    chk(rdat, FAC_RST_WORD);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(8'h40), '0, 1'b1);
    $display("test map done");
    foreach (offs[i]) begin
      bus(1'b1, 1'b1, FAC_SZ_WORD, sa(offs[i]), 32'hA5A5_0000 + 32'(i), 1'b0);
      bus(1'b0, 1'b0, FAC_SZ_WORD, sa(offs[i]), '0, 1'b1);
      bus(1'b1, 1'b1, FAC_SZ_BYTE, sa(offs[i]), 32'h0000_00FF, 1'b1);
      bus(1'b0, 1'b1, FAC_SZ_WORD, sa(offs[i]), '0, 1'b0);
      chk(rdat, 32'hA5A5_0000 + 32'(i));
    end
    $display("test address registers done");
    f.dataViol     = 1'b1;
    f.dataViolAddr = 32'h2000_0003;
    i_core.raise(f);
    chk({31'h0, protValid}, 32'h1);
    handler(FAC_OFF_PFAR, 32'h2000_0003, 32'h0000_0082);
    f              = '0;
    f.preciseBusErr = 1'b1;
    f.busReqAddr   = 32'h2000_0101;
    i_core.raise(f);
    chk({31'h0, busValid}, 32'h1);
    handler(FAC_OFF_BUS_FAULT_ADDRESS, 32'h2000_0101, 32'h0000_8200);
    f              = '0;
    f.dataViol     = 1'b1;
    f.dataViolAddr = 32'h3000_0006;
    i_core.raise(f);
    handler(FAC_OFF_PFAR, 32'h3000_0006, 32'h0000_0082);
    chk({31'h0, busValid}, 32'h0);
    f               = '0;
    f.otherMemFault = 1'b1;
    f.otherBusFault = 1'b1;
    f.dataViolAddr  = 32'h5555_0000;
    f.busReqAddr    = 32'h5555_0000;
    i_core.raise(f);
    chk({30'h0, protValid, busValid}, 32'h2);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(FAC_OFF_BUS_FAULT_ADDRESS), '0, 1'b0);
    chk(rdat, 32'h2000_0101);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(FAC_OFF_PFAR), '0, 1'b0);
    chk(rdat, 32'h3000_0006);
    $display("test fault capture done");
    bus(1'b1, 1'b1, FAC_SZ_BYTE, sa(FAC_OFF_CONFIGURABLE_FAULT_STATUS), 32'h0000_0082, 1'b0);
    chk({31'h0, protValid}, 32'h0);
    foreach (tSz[i]) begin
      bus(1'b0, 1'b1, tSz[i], sa(tOff[i]), '0, tErr[i]);
    end
    bus(1'b1, 1'b1, FAC_SZ_BYTE, sa(8'h19), 32'h0000_AB00, 1'b0);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(FAC_OFF_PRI1), '0, 1'b0);
    chk(rdat, 32'h0000_AB00);
    bus(1'b1, 1'b1, FAC_SZ_WORD, sa(FAC_OFF_VECTOR_TABLE_OFFSET), 32'h0000_0200, 1'b0);
    bus(1'b1, 1'b1, FAC_SZ_WORD, sa(8'h0A), 32'h0000_FE00, 1'b1);
    bus(1'b0, 1'b1, FAC_SZ_WORD, sa(FAC_OFF_VECTOR_TABLE_OFFSET), '0, 1'b0);
    chk(rdat, 32'h0000_0200);
    $display("test access sizes done");
    complete_run();
  end
endmodule : tb
